// ### dmss_disk_model.sv
// Purpose: disk read/write channel model for the sequencer bench
// Assumes: pin pulses four clocks wide, xferDone one clock wide, launched after rising edges
// Notes:   xferDone answers xferReq after lat cycles unless it drops first
`timescale 1ns/100ps
module dmss_disk_model
(
  input  wire logic       clock,
  input  wire logic       xferReq,
  output logic            indexPin,
  output logic            sectorPin,
  output logic            hdrFoundPin,
  output logic            hdrMatchPin,
  output logic [7:0]      hdrSectorPin,
  output logic            xferDone
);
  logic [2:0] strobes;
  int         lat;

  assign {hdrFoundPin, sectorPin, indexPin} = strobes;

  initial
  begin
    strobes = 3'h0;
    hdrMatchPin = 1'b0;
    hdrSectorPin = 8'h5a;
    xferDone = 1'b0;
    lat = 2;
  end

  // ----------------------------------------------------------------
  // pin pulses: 0 index, 1 sector, 2 header found
  // ----------------------------------------------------------------
  task automatic strobe(input int which);
    @(posedge clock);
    strobes[which] <= 1'b1;
    repeat (4) @(posedge clock);
    strobes[which] <= 1'b0;
  endtask

  // header byte settles before the found pulse, scrambled once released
  task automatic hdr(input logic [7:0] sec, input logic match);
    @(posedge clock);
    hdrSectorPin <= sec;
    hdrMatchPin <= match;
    repeat (3) @(posedge clock);
    strobe(2);
    hdrSectorPin <= ~sec;
    hdrMatchPin <= ~match;
  endtask

  // ----------------------------------------------------------------
  // data transfer answer
  // ----------------------------------------------------------------
  always
  begin
    @(posedge clock);
    if (xferReq === 1'b1)
    begin
      for (int i = 0; i < lat && xferReq === 1'b1; i++)
        @(posedge clock);
      if (xferReq === 1'b1)
      begin
        xferDone <= 1'b1;
        @(posedge clock);
        xferDone <= 1'b0;
        @(posedge clock);
      end
    end
  end
endmodule

// ### dmss_pkg.sv
// Purpose: shared constants of the multi-sector disk command sequencer
// Assumes: classic Wishbone, 8-bit registers in the low byte of 32-bit words
// Notes:   states are one-hot
package dmss_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_DRIVE_CMD  = 8'h00;
  localparam logic [7:0] ADR_OP_CMD     = 8'h04;
  localparam logic [7:0] ADR_SECT_OPS   = 8'h08;
  localparam logic [7:0] ADR_SECT_NUM   = 8'h0c;
  localparam logic [7:0] ADR_STATUS     = 8'h10;
  localparam logic [7:0] ADR_ERROR      = 8'h14;
  localparam logic [7:0] ADR_INTERLOCK  = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OC_IRQ_EN      = 0;
  localparam int OC_HDR_IRQ_EN  = 1;
  localparam int OC_INTERLOCK   = 2;
  localparam int OC_START_INDEX = 3;
  localparam int OC_REMOTE_DMA  = 4;
  localparam int DC_COMPARE_HDR = 1;
  localparam int DC_MULTI       = 2;
  localparam int ST_OP_DONE     = 0;
  localparam int ST_HDR_DONE    = 1;
  localparam int ST_ERROR       = 2;
  localparam int ST_NEXT_READY  = 3;
  localparam int ST_BUSY        = 4;
  localparam int ST_ILK_WAIT    = 5;
  localparam int ER_NOT_FOUND   = 0;
  localparam int ER_LATE_ILK    = 1;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [2:0] RST_PEND        = 3'h0;
  localparam logic [1:0] RST_ERR         = 2'h0;
  localparam logic [1:0] INDEX_LIMIT     = 2'h2;
  localparam int         SYNC_WIDTH      = 12;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0001,
    S_WAITIDX = 4'b0010,
    S_SEEK    = 4'b0100,
    S_XFER    = 4'b1000
  } dmss_state_t;

endpackage

// ### dmss_sequencer.sv
// Purpose: multi-sector, interlock and chaining command sequencer
// Assumes: Wishbone slave; channel pins asynchronous; xferDone on clock
// Notes:   one pending command may be queued once the header has passed
// Notes on behaviour
// [R1] sector count of a multi-sector command comes from the operations counter
// [R2] logical mode compares the sector-number counter instead of header sector byte
// [R3] host preloads first sector number and sector count
// [R4] each finished sector decrements operations counter, increments sector number
// [R5] keep seeking and transferring until operations counter is zero
// [R6] operations counter zero at end raises operation-complete interrupt
// [R7] sector not found ends the command early
// [R8] physical mode takes sectors in the order they pass the head
// [R9] physical mode skips header comparison
// [R10] start-at-index bit delays command start to next index pulse; a queued chained command goes straight to seek
// [R11] host loads track sector count for whole-track physical work
// [R12] host sets irq, header irq and interlock bits for interlock mode
// [R13] drive command write starts command; op command may start remote DMA
// [R14] interlock mode raises header-complete once header is located
// [R15] host reloads registers and command after header-complete
// [R16] host writes interlock register after every header-complete
// [R17] missing interlock write before next sector terminates command
// [R18] interlock mode interrupts at end of every header field
// [R19] completion readable from status and error registers
// [R20] new command accepted while old completes once next-command-ready
// [R21] chaining without interlock mode imposes no interlock deadline
// [R22] host uses interlock only for adjacent distinct operations
// [R23] late interlock is reported when next drive command is loaded
// [R24] interrupt causes stay pending until status register is read
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module dmss_sequencer
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic      [31:0] wbDatO,
  output logic             wbAck,
  input  wire logic        indexPin,
  input  wire logic        sectorPin,
  input  wire logic        hdrFoundPin,
  input  wire logic        hdrMatchPin,
  input  wire logic [7:0]  hdrSectorPin,
  input  wire logic        xferDone,
  output logic             xferReq,
  output logic             remoteDmaStart,
  output logic             irq
);

  logic [11:0]          syncBus;
  logic                 indexLvl, sectorLvl, hdrLvl, indexPrev, sectorPrev, hdrPrev;
  logic                 indexEdge, sectorEdge, hdrEdge, hdrMatch;
  logic [7:0]           hdrSector;
  dmss_pkg::dmss_state_t state, next_state;
  logic [7:0]           driveCmd, opCmd, sectorOps, sectorNum, pendCmd;
  logic [7:0]           next_driveCmd, next_opCmd, next_sectorOps, next_sectorNum, next_pendCmd;
  logic [2:0]           pend, next_pend;
  logic [1:0]           errBits, next_errBits, idxCnt, next_idxCnt;
  logic                 waitIlk, next_waitIlk, lateFlag, next_lateFlag;
  logic                 pendValid, next_pendValid;
  logic                 next_xferReq, next_remoteDmaStart, next_irq, next_wbAck;
  logic [31:0]          next_wbDatO;
  logic                 req, wrReq, rdReq, dcWrite, ilkWrite, hostCntWrite;
  logic                 nextReady, hdrAccept, lastSector, lateMiss;

  // ----------------------------------------------------------------
  // pin synchronisation and edges
  // ----------------------------------------------------------------
  dmss_sync #(.WIDTH(dmss_pkg::SYNC_WIDTH)) uSync
  (
    .clock   (clock),
    .arst_n  (arst_n),
    .pinIn   ({indexPin, sectorPin, hdrFoundPin, hdrMatchPin, hdrSectorPin}),
    .syncOut (syncBus)
  );

  assign {indexLvl, sectorLvl, hdrLvl, hdrMatch, hdrSector} = syncBus;
  assign indexEdge  = indexLvl & ~indexPrev;
  assign sectorEdge = sectorLvl & ~sectorPrev;
  assign hdrEdge    = hdrLvl & ~hdrPrev;

  // ----------------------------------------------------------------
  // bus decode and engine conditions
  // ----------------------------------------------------------------
  assign req          = wbCyc & wbStb & ~wbAck;
  assign wrReq        = req & wbWe & wbSel[0];
  assign rdReq        = req & ~wbWe;
  assign dcWrite      = wrReq & (wbAdr == dmss_pkg::ADR_DRIVE_CMD);
  assign ilkWrite     = wrReq & (wbAdr == dmss_pkg::ADR_INTERLOCK);
  assign hostCntWrite = wrReq & ((wbAdr == dmss_pkg::ADR_SECT_OPS)
                                 | (wbAdr == dmss_pkg::ADR_SECT_NUM));
  assign nextReady    = (state == dmss_pkg::S_IDLE) | (state == dmss_pkg::S_XFER);
  // [R2] [R9] logical compare or physical skip
  assign hdrAccept    = (state == dmss_pkg::S_SEEK) & hdrEdge
                        & (~driveCmd[dmss_pkg::DC_COMPARE_HDR]
                           | (hdrMatch & (hdrSector == sectorNum)));
  // [R1] count taken from operations counter
  assign lastSector   = ~driveCmd[dmss_pkg::DC_MULTI] | (sectorOps <= 8'h01);
  // [R17] [R21] deadline only in interlock mode
  assign lateMiss     = sectorEdge & opCmd[dmss_pkg::OC_INTERLOCK] & waitIlk & ~ilkWrite;

  // ----------------------------------------------------------------
  // next-value logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state          = state;
    next_driveCmd       = driveCmd;
    next_opCmd          = opCmd;
    next_sectorOps      = sectorOps;
    next_sectorNum      = sectorNum;
    next_pendCmd        = pendCmd;
    next_pendValid      = pendValid;
    next_pend           = pend;
    next_errBits        = errBits;
    next_idxCnt         = idxCnt;
    next_waitIlk        = waitIlk;
    next_lateFlag       = lateFlag;
    next_xferReq        = xferReq;
    next_remoteDmaStart = 1'b0;
    next_wbAck          = req;
    next_wbDatO         = wbDatO;

    if (rdReq)
    begin
      case (wbAdr)
        dmss_pkg::ADR_DRIVE_CMD: next_wbDatO = {24'h000000, driveCmd};
        dmss_pkg::ADR_OP_CMD:    next_wbDatO = {24'h000000, opCmd};
        dmss_pkg::ADR_SECT_OPS:  next_wbDatO = {24'h000000, sectorOps};
        dmss_pkg::ADR_SECT_NUM:  next_wbDatO = {24'h000000, sectorNum};
        dmss_pkg::ADR_STATUS:    next_wbDatO = {26'h0, waitIlk, ~(state == dmss_pkg::S_IDLE),
                                                nextReady, pend};
        dmss_pkg::ADR_ERROR:     next_wbDatO = {30'h0, errBits};
        default:                 next_wbDatO = 32'h00000000;
      endcase
    end
    // [R24] status read clears causes; later sets win
    if (rdReq && wbAdr == dmss_pkg::ADR_STATUS)
    begin
      next_pend = dmss_pkg::RST_PEND;
    end

    if (wrReq)
    begin
      case (wbAdr)
        dmss_pkg::ADR_OP_CMD:
        begin
          next_opCmd = wbDatI[7:0];
          // [R13] remote DMA kick
          next_remoteDmaStart = wbDatI[dmss_pkg::OC_REMOTE_DMA];
        end
        dmss_pkg::ADR_SECT_OPS:  next_sectorOps = wbDatI[7:0];
        dmss_pkg::ADR_SECT_NUM:  next_sectorNum = wbDatI[7:0];
        dmss_pkg::ADR_INTERLOCK: next_waitIlk   = 1'b0;
        default:                 next_wbDatO    = next_wbDatO;
      endcase
    end

    // [R13] [R20] [R23] drive command accept, queue or late report
    if (dcWrite)
    begin
      if (state == dmss_pkg::S_IDLE && lateFlag)
      begin
        next_lateFlag                     = 1'b0;
        next_errBits[dmss_pkg::ER_LATE_ILK] = 1'b1;
        next_pend[dmss_pkg::ST_ERROR]     = 1'b1;
      end
      else if (state == dmss_pkg::S_IDLE && wbDatI[7:0] != 8'h00)
      begin
        next_driveCmd = wbDatI[7:0];
        next_errBits  = dmss_pkg::RST_ERR;
        next_idxCnt   = 2'h0;
        // [R10] wait for index when selected
        next_state    = opCmd[dmss_pkg::OC_START_INDEX] ? dmss_pkg::S_WAITIDX
                                                        : dmss_pkg::S_SEEK;
      end
      else if (state == dmss_pkg::S_XFER && !pendValid)
      begin
        next_pendCmd   = wbDatI[7:0];
        next_pendValid = 1'b1;
      end
    end

    case (state)
      dmss_pkg::S_IDLE:
      begin
        if (lateMiss)
        begin
          next_lateFlag = 1'b1;
          next_waitIlk  = 1'b0;
        end
      end
      dmss_pkg::S_WAITIDX:
      begin
        // [R10] begin on index pulse
        if (indexEdge)
        begin
          next_state = dmss_pkg::S_SEEK;
        end
      end
      dmss_pkg::S_SEEK:
      begin
        // [R8] take the first acceptable header passing the head
        if (hdrAccept)
        begin
          next_state   = dmss_pkg::S_XFER;
          next_xferReq = 1'b1;
          next_idxCnt  = 2'h0;
          // [R14] [R18] header complete cause
          if (opCmd[dmss_pkg::OC_HDR_IRQ_EN])
          begin
            next_pend[dmss_pkg::ST_HDR_DONE] = 1'b1;
          end
          if (opCmd[dmss_pkg::OC_INTERLOCK])
          begin
            next_waitIlk = 1'b1;
          end
        end
        else if (indexEdge)
        begin
          next_idxCnt = idxCnt + 2'h1;
          // [R7] two index pulses without the sector
          if (idxCnt == dmss_pkg::INDEX_LIMIT - 2'h1)
          begin
            next_state                           = dmss_pkg::S_IDLE;
            next_errBits[dmss_pkg::ER_NOT_FOUND] = 1'b1;
            next_pend[dmss_pkg::ST_ERROR]        = 1'b1;
            next_pendValid                       = 1'b0;
          end
        end
      end
      dmss_pkg::S_XFER:
      begin
        if (xferDone)
        begin
          next_xferReq = 1'b0;
          // [R4] per-sector counter update
          next_sectorOps = sectorOps - 8'h01;
          next_sectorNum = sectorNum + 8'h01;
          if (lastSector)
          begin
            // [R6] [R19] operation complete
            next_pend[dmss_pkg::ST_OP_DONE] = 1'b1;
            next_sectorOps                  = dmss_pkg::RST_BYTE;
            if (next_pendValid)
            begin
              next_driveCmd  = next_pendCmd;
              next_pendValid = 1'b0;
              next_state     = dmss_pkg::S_SEEK;
            end
            else
            begin
              next_state = dmss_pkg::S_IDLE;
            end
          end
          else
          begin
            // [R5] go after the next sector
            next_state = dmss_pkg::S_SEEK;
          end
        end
      end
      default:
      begin
        next_state = dmss_pkg::S_IDLE;
      end
    endcase

    // [R17] interlock deadline missed while active
    if (state != dmss_pkg::S_IDLE && lateMiss)
    begin
      next_state     = dmss_pkg::S_IDLE;
      next_xferReq   = 1'b0;
      next_pendValid = 1'b0;
      next_waitIlk   = 1'b0;
      next_lateFlag  = 1'b1;
    end

    next_irq = next_opCmd[dmss_pkg::OC_IRQ_EN]
               & (next_pend[dmss_pkg::ST_OP_DONE] | next_pend[dmss_pkg::ST_ERROR]
                  | (next_opCmd[dmss_pkg::OC_HDR_IRQ_EN] & next_pend[dmss_pkg::ST_HDR_DONE]));
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state          <= dmss_pkg::S_IDLE;
      driveCmd       <= dmss_pkg::RST_BYTE;
      opCmd          <= dmss_pkg::RST_BYTE;
      sectorOps      <= dmss_pkg::RST_BYTE;
      sectorNum      <= dmss_pkg::RST_BYTE;
      pendCmd        <= dmss_pkg::RST_BYTE;
      pendValid      <= 1'b0;
      pend           <= dmss_pkg::RST_PEND;
      errBits        <= dmss_pkg::RST_ERR;
      idxCnt         <= 2'h0;
      waitIlk        <= 1'b0;
      lateFlag       <= 1'b0;
      xferReq        <= 1'b0;
      remoteDmaStart <= 1'b0;
      irq            <= 1'b0;
      wbAck          <= 1'b0;
      wbDatO         <= 32'h00000000;
      indexPrev      <= 1'b0;
      sectorPrev     <= 1'b0;
      hdrPrev        <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      driveCmd       <= next_driveCmd;
      opCmd          <= next_opCmd;
      sectorOps      <= next_sectorOps;
      sectorNum      <= next_sectorNum;
      pendCmd        <= next_pendCmd;
      pendValid      <= next_pendValid;
      pend           <= next_pend;
      errBits        <= next_errBits;
      idxCnt         <= next_idxCnt;
      waitIlk        <= next_waitIlk;
      lateFlag       <= next_lateFlag;
      xferReq        <= next_xferReq;
      remoteDmaStart <= next_remoteDmaStart;
      irq            <= next_irq;
      wbAck          <= next_wbAck;
      wbDatO         <= next_wbDatO;
      indexPrev      <= indexLvl;
      sectorPrev     <= sectorLvl;
      hdrPrev        <= hdrLvl;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  sequence sectorFinish;
    (state == dmss_pkg::S_XFER) && xferDone && !hostCntWrite && !lateMiss;
  endsequence

  sequence seekTimeout;
    (state == dmss_pkg::S_SEEK) && !hdrAccept && indexEdge && idxCnt == 2'h1 && !lateMiss;
  endsequence

  chk_count_step: assert property ((sectorFinish and !lastSector) |=> // R4
    sectorOps == $past(sectorOps) - 8'h01 && sectorNum == $past(sectorNum) + 8'h01)
    else $error("sector counters not stepped");

  chk_multi_continue: assert property ((sectorFinish and !lastSector) |=> // R5
    state == dmss_pkg::S_SEEK && !xferReq)
    else $error("multi-sector did not continue");

  chk_op_complete: assert property ((sectorFinish and (lastSector && !pendValid && !dcWrite)) // R6
    |=> pend[dmss_pkg::ST_OP_DONE] && state == dmss_pkg::S_IDLE && sectorOps == 8'h00)
    else $error("completion not flagged");

  chk_not_found: assert property (seekTimeout |=> // R7
    state == dmss_pkg::S_IDLE && errBits[dmss_pkg::ER_NOT_FOUND] && pend[dmss_pkg::ST_ERROR])
    else $error("missing sector not ended");

  chk_logical_cmp: assert property ((state == dmss_pkg::S_SEEK) && hdrEdge // R2
    && driveCmd[dmss_pkg::DC_COMPARE_HDR] && hdrSector != sectorNum && !lateMiss
    |=> state != dmss_pkg::S_XFER)
    else $error("wrong sector accepted");

  chk_physical_skip: assert property ((state == dmss_pkg::S_SEEK) && hdrEdge // R9
    && !driveCmd[dmss_pkg::DC_COMPARE_HDR] && !lateMiss |=> state == dmss_pkg::S_XFER && xferReq)
    else $error("physical header not taken");

  chk_index_wait: assert property ((state == dmss_pkg::S_WAITIDX) && !indexEdge && !lateMiss // R10
    |=> state == dmss_pkg::S_WAITIDX ##1 !xferReq)
    else $error("started before index");

  chk_header_irq: assert property (hdrAccept && opCmd[dmss_pkg::OC_HDR_IRQ_EN] // R14
    && opCmd[dmss_pkg::OC_IRQ_EN] && !lateMiss |=> pend[dmss_pkg::ST_HDR_DONE] ##1 irq)
    else $error("header complete not raised");

  chk_ilk_deadline: assert property ((state != dmss_pkg::S_IDLE) && lateMiss // R17
    |=> state == dmss_pkg::S_IDLE && !xferReq && lateFlag)
    else $error("late interlock not terminated");

  chk_no_deadline: assert property (sectorEdge && !opCmd[dmss_pkg::OC_INTERLOCK] // R21
    && (state == dmss_pkg::S_XFER) && !xferDone |=> state == dmss_pkg::S_XFER)
    else $error("chaining hit a deadline");

  chk_late_report: assert property ((state == dmss_pkg::S_IDLE) && lateFlag && dcWrite // R23
    |=> errBits[dmss_pkg::ER_LATE_ILK] && pend[dmss_pkg::ST_ERROR] && state == dmss_pkg::S_IDLE)
    else $error("late interlock not reported");

  chk_dma_kick: assert property (wrReq && wbAdr == dmss_pkg::ADR_OP_CMD // R13
    && wbDatI[dmss_pkg::OC_REMOTE_DMA] |=> remoteDmaStart ##1 !remoteDmaStart)
    else $error("remote DMA start not pulsed");

endmodule

// ### dmss_sequencer_tb.sv
// Purpose: self-checking bench of the multi-sector command sequencer
// Assumes: Wishbone reads answered one cycle after they are taken
// Notes:   expected read values are queued by the driver, compared by a monitor
`timescale 1ns/100ps
module dmss_sequencer_tb;
  logic        clock, arst_n, wbCyc, wbStb, wbWe, wbAck, xferDone, xferReq;
  logic        indexPin, sectorPin, hdrFoundPin, hdrMatchPin, remoteDmaStart, irq;
  logic [7:0]  wbAdr, hdrSectorPin, start;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, seed;
  logic [31:0] expQ[$];
  int          failCount, totalChecks, dmaPulses, cycles;

  dmss_sequencer uut (.clock(clock), .arst_n(arst_n), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .indexPin(indexPin), .sectorPin(sectorPin), .hdrFoundPin(hdrFoundPin),
    .hdrMatchPin(hdrMatchPin), .hdrSectorPin(hdrSectorPin), .xferDone(xferDone),
    .xferReq(xferReq), .remoteDmaStart(remoteDmaStart), .irq(irq));
  dmss_disk_model disk (.clock(clock), .xferReq(xferReq), .indexPin(indexPin),
    .sectorPin(sectorPin), .hdrFoundPin(hdrFoundPin), .hdrMatchPin(hdrMatchPin),
    .hdrSectorPin(hdrSectorPin), .xferDone(xferDone));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // compare, report, bus access
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                     input logic sel0);
    int n;
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= {3'($random(seed)), sel0};
    wbDatI <= {24'($random(seed)), dat};
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    if (n >= 50)
      failCount++;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 1'b1);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(1'b0, adr, 8'h00, 1'b1);
  endtask

  task automatic waitx(input logic val);
    for (int n = 0; n < 300 && xferReq !== val; n++)
      @(posedge clock);
    if (xferReq !== val)
      failCount++;
  endtask

  // ----------------------------------------------------------------
  // monitor and timeout
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
      check(wbDatO, expQ.pop_front());
    if (remoteDmaStart === 1'b1)
      dmaPulses++;
    cycles++;
    if (cycles == 20000)
    begin
      failCount++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {arst_n, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = '0;
    seed = 32'hb473;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    rd(dmss_pkg::ADR_STATUS, 32'h08);
    rd(dmss_pkg::ADR_ERROR, 32'h00);
    rd(8'h1c, 32'h00);
    bus(1'b1, dmss_pkg::ADR_SECT_OPS, 8'h33, 1'b0);
    rd(dmss_pkg::ADR_SECT_OPS, 32'h00);
    $display("registers test done");
    start = 8'($random(seed)) & 8'h7f;
    wr(dmss_pkg::ADR_SECT_OPS, 8'h03);
    wr(dmss_pkg::ADR_SECT_NUM, start);
    wr(dmss_pkg::ADR_OP_CMD, 8'h01);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h06);
    disk.hdr(start + 8'h05, 1'b1);
    disk.hdr(start, 1'b0);
    repeat (8) @(posedge clock);
    check(32'(xferReq), 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      disk.hdr(start + 8'(i), 1'b1);
      waitx(1'b1);
      check(32'(xferReq), 32'h1);
      waitx(1'b0);
    end
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    rd(dmss_pkg::ADR_SECT_OPS, 32'h00);
    rd(dmss_pkg::ADR_SECT_NUM, 32'(start + 8'h03));
    rd(dmss_pkg::ADR_STATUS, 32'h09);
    rd(dmss_pkg::ADR_STATUS, 32'h08);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    $display("logical test done");
    wr(dmss_pkg::ADR_SECT_OPS, 8'h01);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h06);
    disk.strobe(0);
    disk.strobe(0);
    repeat (8) @(posedge clock);
    check(32'(irq), 32'h1);
    rd(dmss_pkg::ADR_ERROR, 32'h01);
    rd(dmss_pkg::ADR_STATUS, 32'h0c);
    $display("not found test done");
    wr(dmss_pkg::ADR_SECT_OPS, 8'h02);
    wr(dmss_pkg::ADR_SECT_NUM, start);
    wr(dmss_pkg::ADR_OP_CMD, 8'h09);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    disk.hdr(8'h07, 1'b0);
    repeat (8) @(posedge clock);
    check(32'(xferReq), 32'h0);
    disk.strobe(0);
    for (int i = 0; i < 2; i++)
    begin
      disk.hdr(i == 0 ? 8'h07 : 8'h03, 1'b0);
      waitx(1'b1);
      check(32'(xferReq), 32'h1);
      waitx(1'b0);
    end
    rd(dmss_pkg::ADR_SECT_NUM, 32'(start + 8'h02));
    rd(dmss_pkg::ADR_STATUS, 32'h09);
    wr(dmss_pkg::ADR_OP_CMD, 8'h10);
    repeat (2) @(posedge clock);
    check(32'(dmaPulses), 32'h1);
    $display("physical test done");
    disk.lat = 60;
    wr(dmss_pkg::ADR_SECT_OPS, 8'h01);
    wr(dmss_pkg::ADR_OP_CMD, 8'h03);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    disk.hdr(8'h11, 1'b1);
    waitx(1'b1);
    rd(dmss_pkg::ADR_STATUS, 32'h1a);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    disk.strobe(1);
    check(32'(xferReq), 32'h1);
    waitx(1'b0);
    disk.hdr(8'h12, 1'b1);
    waitx(1'b1);
    check(32'(xferReq), 32'h1);
    waitx(1'b0);
    repeat (2) @(posedge clock);
    rd(dmss_pkg::ADR_STATUS, 32'h0b);
    $display("chaining test done");
    // interlock bits set, interlock write withheld
    wr(dmss_pkg::ADR_SECT_OPS, 8'h02);
    wr(dmss_pkg::ADR_OP_CMD, 8'h07);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    disk.hdr(8'h21, 1'b1);
    waitx(1'b1);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    rd(dmss_pkg::ADR_STATUS, 32'h3a);
    disk.strobe(1);
    waitx(1'b0);
    check(32'(xferReq), 32'h0);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    rd(dmss_pkg::ADR_ERROR, 32'h02);
    rd(dmss_pkg::ADR_STATUS, 32'h0c);
    $display("interlock test done");
    // adjacent sectors: drive command left as is
    wr(dmss_pkg::ADR_SECT_OPS, 8'h02);
    wr(dmss_pkg::ADR_DRIVE_CMD, 8'h04);
    for (int i = 0; i < 2; i++)
    begin
      disk.hdr(8'h31 + 8'(i), 1'b1);
      waitx(1'b1);
      rd(dmss_pkg::ADR_STATUS, 32'h3a);
      wr(dmss_pkg::ADR_INTERLOCK, 8'h00);
      disk.strobe(1);
      check(32'(xferReq), 32'h1);
      waitx(1'b0);
    end
    rd(dmss_pkg::ADR_ERROR, 32'h00);
    rd(dmss_pkg::ADR_STATUS, 32'h09);
    $display("interlock write test done");
    repeat (2) @(posedge clock);
    tally_and_finish();
  end
endmodule

// ### dmss_sync.sv
// Purpose: two-flop synchroniser for channel pins
// Assumes: each bit is a slow level or a pulse wider than two clocks
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
module dmss_sync
#(
  parameter int WIDTH = dmss_pkg::SYNC_WIDTH
)
(
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // per-bit flop pairs
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1[i]  <= 1'b0;
          syncOut[i] <= 1'b0;
        end
        else
        begin
          stage1[i]  <= pinIn[i];
          syncOut[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule
